// ==== pkg/tvm_regs.svh ====
// Offsets, field positions, reset values and timing of the monitor
// configuration and event gate bank.
// Assumes inclusion by bare name from tvm_pkg.
`ifndef TVM_REGS_SVH
`define TVM_REGS_SVH
`define TVM_OFS_SETUP 8'h18
`define TVM_OFS_CYCLE 8'h19
`define TVM_OFS_SPEED 8'h1A
`define TVM_OFS_GATE_LO 8'h1D
`define TVM_OFS_GATE_HI 8'h1E
`define TVM_RST_SETUP 8'h00
`define TVM_RST_CYCLE 8'h00
`define TVM_RST_SPEED 8'h00
`define TVM_RST_GATE 8'h00
`define TVM_BIT_MON_START 0
`define TVM_BIT_PIN_LO 1
`define TVM_BIT_STANDBY 7
`define TVM_BIT_SINGLE 4
`define TVM_BIT_AVG_OFF 5
`define TVM_BIT_TO_EN 6
`define TVM_BIT_SRST 7
`define TVM_BIT_FAST 0
`define TVM_BIT_REF_SUPPLY 4
`define TVM_PIN_EXT_DIODE 2'h2
`define TVM_GATE_HI_USED 5
`define TVM_AVG_COUNT 16
`define TVM_SYS_HZ 100000000
`define TVM_TIMEOUT_US 25000
`define TVM_SLOW_HZ 1400
`define TVM_FAST_HZ 22500
`endif

// ==== pkg/tvm_pkg.sv ====
// Types shared by the monitor configuration bank.
// Assumes tvm_regs.svh is on the include path.
`include "tvm_regs.svh"
package tvm_pkg;
  typedef enum logic [3:0] {
    TVM_CH_SUPPLY = 4'h0,
    TVM_CH_INT_TEMP = 4'h1,
    TVM_CH_EXT_OR_IN1 = 4'h2,
    TVM_CH_IN2 = 4'h3,
    TVM_CH_IN3 = 4'h4,
    TVM_CH_IN4 = 4'h5,
    TVM_CH_IN5 = 4'h6,
    TVM_CH_IN6 = 4'h7,
    TVM_CH_IN7 = 4'h8,
    TVM_CH_IN8 = 4'h9
  } tvm_chan_t;
  typedef enum logic [1:0] {
    TVM_LK_IDLE = 2'h0,
    TVM_LK_WAIT = 2'h1,
    TVM_LK_DONE = 2'h3
  } tvm_lk_state_t;
endpackage : tvm_pkg

// ==== logic/tvm_cfg_regs.sv ====
// Configuration and event gate bank of the temperature and voltage monitor.
// Assumes a serial engine on link_clk issues one register request at a
// time and the converter logic shares sys_clk.
`timescale 1ns/10ps
`include "tvm_regs.svh"
module tvm_cfg_regs #(
  parameter int TIMEOUT_CYC = `TVM_SYS_HZ / 1000000 * `TVM_TIMEOUT_US,
  parameter int SLOW_CYC = `TVM_SYS_HZ / `TVM_SLOW_HZ,
  parameter int FAST_CYC = `TVM_SYS_HZ / `TVM_FAST_HZ
) (
  // System
  input wire logic sys_clk,
  input wire logic rst,
  // Register requests from the serial engine
  input wire logic link_clk,
  input wire logic link_req,
  input wire logic link_wr,
  input wire logic [7:0] link_addr,
  input wire logic [7:0] link_wdata,
  output logic link_busy,
  output logic link_done,
  output logic [7:0] link_rdata,
  // Serial clock watch
  input wire logic scl_pin,
  input wire logic xfer_active,
  output logic bus_abort,
  // Converter control
  output logic conv_run,
  output logic standby_bit,
  output logic conv_single,
  output tvm_pkg::tvm_chan_t conv_chan,
  output logic conv_ext_diode,
  output logic avg_en,
  output logic timeout_en,
  output logic fast_mode,
  output logic filter_bypass,
  output logic ref_supply,
  output logic adc_tick,
  // Events
  input wire logic [12:0] event_raw,
  output logic [12:0] event_pass
);
  import tvm_pkg::*;

  if (TIMEOUT_CYC < 2 || SLOW_CYC < 2 || FAST_CYC < 2 ||
      FAST_CYC > SLOW_CYC || TIMEOUT_CYC >= (1 << 24) ||
      SLOW_CYC >= (1 << 20)) begin : g_bad_param
    $error("tvm_cfg_regs: timing parameters out of range");
  end

  logic [7:0] setup_reg, cycle_reg, speed_reg, gate_lo_reg, gate_hi_reg;
  logic [7:0] rd_reg;
  logic req_s1, req_s2, req_s3, ack_tgl_reg;
  logic lk_req_tgl, ack_s1, ack_s2, ack_s3;
  logic lk_rst_s1, lk_rst_s2, lk_rst_s3, lk_rst;
  logic lk_wr_hold;
  logic [7:0] lk_addr_hold, lk_wdata_hold;
  tvm_lk_state_t lk_state_reg;
  logic scl_s1, scl_s2, scl_s3, scl_level;
  logic [23:0] to_cnt_reg;
  logic to_fired_reg;
  logic [19:0] tick_cnt_reg;
  logic fire, wr_hit, soft_rst;

  // Link side: hold the request and signal it by a toggle
  always_ff @(posedge link_clk)
  begin
    lk_rst_s1 <= rst;
    lk_rst_s2 <= lk_rst_s1;
    lk_rst_s3 <= lk_rst_s2;
    if (lk_rst_s2 == lk_rst_s3)
      lk_rst <= lk_rst_s3;
  end

  always_ff @(posedge link_clk)
  begin
    ack_s1 <= ack_tgl_reg;
    ack_s2 <= ack_s1;
    ack_s3 <= ack_s2;
  end

  always_ff @(posedge link_clk)
  begin
    if (lk_rst)
    begin
      lk_state_reg <= TVM_LK_IDLE;
      lk_req_tgl <= 1'b0;
      lk_wr_hold <= 1'b0;
      lk_addr_hold <= 8'h00;
      lk_wdata_hold <= 8'h00;
      link_busy <= 1'b0;
      link_done <= 1'b0;
      link_rdata <= 8'h00;
    end
    else
    begin
      link_done <= 1'b0;
      case (lk_state_reg)
        TVM_LK_IDLE:
          if (link_req)
          begin
            lk_wr_hold <= link_wr;
            lk_addr_hold <= link_addr;
            lk_wdata_hold <= link_wdata;
            lk_req_tgl <= ~lk_req_tgl;
            link_busy <= 1'b1;
            lk_state_reg <= TVM_LK_WAIT;
          end
        TVM_LK_WAIT:
          // Read data stays still in the other domain until the next request
          if (ack_s2 == ack_s3 && ack_s3 == lk_req_tgl)
          begin
            link_rdata <= rd_reg;
            link_done <= 1'b1;
            link_busy <= 1'b0;
            lk_state_reg <= TVM_LK_DONE;
          end
        TVM_LK_DONE:
          lk_state_reg <= TVM_LK_IDLE;
        default:
          lk_state_reg <= TVM_LK_IDLE;
      endcase
    end
  end

  // System side: take the request once both late stages agree
  always_ff @(posedge sys_clk)
  begin
    req_s1 <= lk_req_tgl;
    req_s2 <= req_s1;
    req_s3 <= req_s2;
  end

  assign fire = (req_s2 == req_s3) && (req_s3 != ack_tgl_reg);
  assign wr_hit = fire && lk_wr_hold;
  assign soft_rst = wr_hit && lk_addr_hold == `TVM_OFS_CYCLE &&
                    lk_wdata_hold[`TVM_BIT_SRST];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ack_tgl_reg <= 1'b0;
      rd_reg <= 8'h00;
    end
    else if (fire)
    begin
      ack_tgl_reg <= ~ack_tgl_reg;
      if (lk_addr_hold == `TVM_OFS_SETUP)
        rd_reg <= setup_reg;
      else if (lk_addr_hold == `TVM_OFS_CYCLE)
        rd_reg <= cycle_reg;
      else if (lk_addr_hold == `TVM_OFS_SPEED)
        rd_reg <= speed_reg;
      else if (lk_addr_hold == `TVM_OFS_GATE_LO)
        rd_reg <= gate_lo_reg;
      else if (lk_addr_hold == `TVM_OFS_GATE_HI)
        rd_reg <= gate_hi_reg;
      else
        rd_reg <= 8'h00;
    end
  end

  // Register bank; reserved speed and gate bits are stored as written
  always_ff @(posedge sys_clk)
  begin
    if (rst || soft_rst)
    begin
      setup_reg <= `TVM_RST_SETUP;
      cycle_reg <= `TVM_RST_CYCLE;
      speed_reg <= `TVM_RST_SPEED;
      gate_lo_reg <= `TVM_RST_GATE;
      gate_hi_reg <= `TVM_RST_GATE;
    end
    else if (wr_hit)
    begin
      if (lk_addr_hold == `TVM_OFS_SETUP)
        setup_reg <= lk_wdata_hold;
      else if (lk_addr_hold == `TVM_OFS_CYCLE)
        cycle_reg <= lk_wdata_hold;
      else if (lk_addr_hold == `TVM_OFS_SPEED)
        speed_reg <= lk_wdata_hold;
      else if (lk_addr_hold == `TVM_OFS_GATE_LO)
        gate_lo_reg <= lk_wdata_hold;
      else if (lk_addr_hold == `TVM_OFS_GATE_HI)
        gate_hi_reg <= lk_wdata_hold;
    end
  end

  // Converter control decoded from the bank
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      conv_run <= 1'b0;
      standby_bit <= 1'b0;
      conv_single <= 1'b0;
      conv_chan <= TVM_CH_SUPPLY;
      conv_ext_diode <= 1'b0;
      avg_en <= 1'b1;
      timeout_en <= 1'b0;
      fast_mode <= 1'b0;
      filter_bypass <= 1'b0;
      ref_supply <= 1'b0;
    end
    else
    begin
      standby_bit <= setup_reg[`TVM_BIT_STANDBY];
      conv_run <= setup_reg[`TVM_BIT_MON_START] &
                  ~setup_reg[`TVM_BIT_STANDBY];
      conv_single <= cycle_reg[`TVM_BIT_SINGLE];
      conv_chan <= tvm_chan_t'(cycle_reg[3:0]);
      // Undefined pin-pair codes fall back to the input pair
      conv_ext_diode <= setup_reg[`TVM_BIT_PIN_LO +: 2] ==
                        `TVM_PIN_EXT_DIODE;
      avg_en <= ~cycle_reg[`TVM_BIT_AVG_OFF];
      timeout_en <= cycle_reg[`TVM_BIT_TO_EN];
      fast_mode <= speed_reg[`TVM_BIT_FAST];
      filter_bypass <= speed_reg[`TVM_BIT_FAST];
      ref_supply <= speed_reg[`TVM_BIT_REF_SUPPLY];
    end
  end

  // Event gating
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      event_pass <= 13'h0000;
    else
      event_pass <= event_raw &
        ~{gate_hi_reg[`TVM_GATE_HI_USED-1:0], gate_lo_reg};
  end

  // Converter clock; stops while monitoring is off
  always_ff @(posedge sys_clk)
  begin
    if (rst || !conv_run)
    begin
      tick_cnt_reg <= 20'h00000;
      adc_tick <= 1'b0;
    end
    else if (tick_cnt_reg >= (fast_mode ? 20'(FAST_CYC - 1) :
                              20'(SLOW_CYC - 1)))
    begin
      tick_cnt_reg <= 20'h00000;
      adc_tick <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 20'h00001;
      adc_tick <= 1'b0;
    end
  end

  // Serial clock watch; only the low phase can hang the data line
  always_ff @(posedge sys_clk)
  begin
    scl_s1 <= scl_pin;
    scl_s2 <= scl_s1;
    scl_s3 <= scl_s2;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      scl_level <= 1'b1;
    else if (scl_s2 == scl_s3)
      scl_level <= scl_s3;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || !timeout_en || !xfer_active || scl_level)
    begin
      to_cnt_reg <= 24'h000000;
      to_fired_reg <= 1'b0;
      bus_abort <= 1'b0;
    end
    else if (to_cnt_reg >= 24'(TIMEOUT_CYC - 1))
    begin
      bus_abort <= ~to_fired_reg;
      to_fired_reg <= 1'b1;
    end
    else
    begin
      to_cnt_reg <= to_cnt_reg + 24'h000001;
      bus_abort <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_srst_write;
    soft_rst;
  endsequence
  sequence s_defaults;
    setup_reg == 8'h00 && cycle_reg == 8'h00 && speed_reg == 8'h00 &&
    gate_lo_reg == 8'h00 && gate_hi_reg == 8'h00;
  endsequence
  sequence s_single_set;
    wr_hit && lk_addr_hold == `TVM_OFS_CYCLE &&
    lk_wdata_hold[`TVM_BIT_SINGLE] && !lk_wdata_hold[`TVM_BIT_SRST];
  endsequence
  property p_chan_follows;
    conv_chan == $past(cycle_reg[3:0]);
  endproperty
  a_chan_follows: assert property (p_chan_follows)
    else $error("channel output does not follow select field");
  property p_ext_diode;
    ##1 conv_ext_diode == ($past(setup_reg[2:1]) == 2'h2);
  endproperty
  a_ext_diode: assert property (p_ext_diode)
    else $error("external diode select wrong");
  property p_single_mode;
    s_single_set |-> ##2 conv_single;
  endproperty
  a_single_mode: assert property (p_single_mode)
    else $error("single mode not entered after write");
  property p_avg;
    ##1 avg_en != $past(cycle_reg[5]);
  endproperty
  a_avg: assert property (p_avg)
    else $error("averaging enable wrong");
  property p_no_abort_off;
    !timeout_en |=> !bus_abort;
  endproperty
  a_no_abort_off: assert property (p_no_abort_off)
    else $error("abort while timeout disabled");
  property p_abort_once;
    bus_abort |=> !bus_abort;
  endproperty
  a_abort_once: assert property (p_abort_once)
    else $error("abort longer than one cycle");
  property p_soft_reset;
    s_srst_write |=> s_defaults;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset left a register set");
  property p_tick_gap;
    adc_tick && fast_mode && conv_run |=> !adc_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("converter ticks too close");
  property p_filter;
    ##1 filter_bypass == $past(speed_reg[0]);
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter bypass disagrees with speed");
  property p_ref;
    ##1 ref_supply == $past(speed_reg[4]);
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference select wrong");
  property p_gate;
    ##1 event_pass == ($past(event_raw) &
      ~{$past(gate_hi_reg[4:0]), $past(gate_lo_reg)});
  endproperty
  a_gate: assert property (p_gate)
    else $error("event gating wrong");
  property p_no_run;
    !setup_reg[0] |=> !conv_run ##1 !adc_tick;
  endproperty
  a_no_run: assert property (p_no_run)
    else $error("conversion running while monitoring stopped");
endmodule : tvm_cfg_regs

// ==== tb/tvm_link_host.sv ====
// Model of the serial engine that issues register requests on link_clk.
// Assumes the bank answers each request with a one-cycle done pulse.
`timescale 1ns/10ps
module tvm_link_host (
  // Link clock and answers
  input wire logic link_clk,
  input wire logic link_done,
  input wire logic [7:0] link_rdata,
  // Requests
  output logic link_req,
  output logic link_wr,
  output logic [7:0] link_addr,
  output logic [7:0] link_wdata
);
  initial
  begin
    link_req = 1'b0;
    link_wr = 1'b0;
    link_addr = 8'h00;
    link_wdata = 8'h00;
  end

  // Qualifiers held until done; inverted afterwards so stale data is caught
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    int n;
    begin
      n = 0;
      @(negedge link_clk);
      link_req = 1'b1;
      link_wr = w;
      link_addr = a;
      link_wdata = d;
      @(negedge link_clk);
      link_req = 1'b0;
      while (link_done !== 1'b1 && n < 60)
      begin
        @(negedge link_clk);
        n++;
      end
      q = link_rdata;
      ok = (n < 60);
      link_wr = ~w;
      link_addr = ~a;
      link_wdata = ~d;
      repeat (2) @(negedge link_clk);
    end
  endtask : xfer
endmodule : tvm_link_host

// ==== tb/tvm_cfg_regs_tb.sv ====
// Self-checking bench for the monitor configuration and event gate bank.
// Assumes short count parameters; the host model drives the link side.
`timescale 1ns/10ps
module tvm_cfg_regs_tb;
  import tvm_pkg::*;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic scl_pin = 1'b1;
  logic xfer_active = 1'b0;
  logic [12:0] event_raw = 13'h0000;
  logic link_req, link_wr, link_busy, link_done, bus_abort, conv_run;
  logic [7:0] link_addr, link_wdata, link_rdata;
  logic standby_bit, conv_single, conv_ext_diode, avg_en, timeout_en;
  logic fast_mode, filter_bypass, ref_supply, adc_tick;
  logic [12:0] event_pass;
  tvm_chan_t conv_chan;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;

  always #5 sys_clk = ~sys_clk;
  initial
  begin
    #3;
    forever #6 link_clk = ~link_clk;
  end

  tvm_cfg_regs #(.TIMEOUT_CYC(50), .SLOW_CYC(40), .FAST_CYC(10)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
    .link_req(link_req), .link_wr(link_wr), .link_addr(link_addr),
    .link_wdata(link_wdata), .link_busy(link_busy),
    .link_done(link_done), .link_rdata(link_rdata), .scl_pin(scl_pin),
    .xfer_active(xfer_active), .bus_abort(bus_abort),
    .conv_run(conv_run), .standby_bit(standby_bit),
    .conv_single(conv_single), .conv_chan(conv_chan),
    .conv_ext_diode(conv_ext_diode), .avg_en(avg_en),
    .timeout_en(timeout_en), .fast_mode(fast_mode),
    .filter_bypass(filter_bypass), .ref_supply(ref_supply),
    .adc_tick(adc_tick), .event_raw(event_raw), .event_pass(event_pass));

  tvm_link_host host (.link_clk(link_clk), .link_done(link_done),
    .link_rdata(link_rdata), .link_req(link_req), .link_wr(link_wr),
    .link_addr(link_addr), .link_wdata(link_wdata));

  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    host.xfer(1'b1, a, d, q, ok);
    chk(13'(ok), 13'h0001);
    // Decoded outputs land a few sys_clk edges after the register
    repeat (3) @(negedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    host.xfer(1'b0, a, 8'h00, q, ok);
    chk({4'h0, ok, q}, {4'h0, 1'b1, e});
  endtask : rd

  // Cycles from the next tick to the one after it
  task automatic tick_gap(output int g);
    g = 0;
    while (adc_tick !== 1'b1 && g < 200)
    begin
      @(negedge sys_clk);
      g++;
    end
    g = 0;
    do
    begin
      @(negedge sys_clk);
      g++;
    end
    while (adc_tick !== 1'b1 && g < 200);
  endtask : tick_gap

  // Holds the serial clock low and counts cycles to an abort
  task automatic scl_low(output int g);
    g = 0;
    xfer_active = 1'b1;
    scl_pin = 1'b0;
    while (bus_abort !== 1'b1 && g < 120)
    begin
      @(negedge sys_clk);
      g++;
    end
    scl_pin = 1'b1;
    xfer_active = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask : scl_low

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // A hang ends the run as a failure
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      final_report();
    end
  end

  initial
  begin
    // Three cycles span two link clock edges, enough for its synchroniser
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    chk({avg_en, conv_single, 4'(conv_chan)}, 6'h20);
    chk({conv_run, timeout_en, fast_mode, ref_supply}, 4'h0);
    repeat (6) @(negedge link_clk);
    rd(8'h18, 8'h00);
    fork
      rd(8'h19, 8'h00);
      begin
        repeat (3) @(negedge link_clk);
        chk(13'(link_busy), 13'h0001);
      end
    join
    chk(13'(link_busy), 13'h0000);
    rd(8'h1A, 8'h00);
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'h00);
    wr(8'h1B, 8'h5A);
    rd(8'h1B, 8'h00);
    // Reserved select codes are never written
    for (int c = 0; c < 10; c++)
    begin
      wr(8'h19, 8'h10 | 8'(c));
      chk({conv_single, 4'(conv_chan)}, 5'h10 | 5'(c));
    end
    wr(8'h19, 8'h62);
    chk({conv_single, avg_en, timeout_en}, 3'h1);
    rd(8'h19, 8'h62);
    wr(8'h18, 8'h05);
    chk({conv_ext_diode, conv_run}, 2'h3);
    wr(8'h18, 8'h03);
    chk(13'(conv_ext_diode), 13'h0000);
    tick_gap(n);
    chk(13'(n), 13'd40);
    // Bit 3 written as 1, other reserved bits as 0
    wr(8'h1A, 8'h19);
    chk({fast_mode, filter_bypass, ref_supply}, 3'h7);
    rd(8'h1A, 8'h19);
    tick_gap(n);
    chk(13'(n), 13'd10);
    wr(8'h18, 8'h81);
    chk({standby_bit, conv_run}, 2'h2);
    scl_low(n);
    chk(13'(n >= 50 && n <= 56), 13'h0001);
    wr(8'h19, 8'h00);
    scl_low(n);
    chk(13'(n), 13'd120);
    event_raw = 13'h1FFF;
    for (int i = 0; i < 13; i++)
    begin
      wr(8'h1D, 8'(13'h0001 << i));
      wr(8'h1E, 8'((13'h0001 << i) >> 8));
      chk(event_pass, ~(13'h0001 << i));
    end
    wr(8'h1D, 8'h00);
    chk(event_pass, 13'h0FFF);
    wr(8'h1D, 8'hA5);
    wr(8'h80 ^ 8'h99, 8'h80);
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'h00);
    rd(8'h1A, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h00);
    chk({avg_en, conv_run, fast_mode, 4'(conv_chan)}, 7'h40);
    final_report();
  end
endmodule : tvm_cfg_regs_tb
